// ### fmsp_params.svh
// register map, field positions, reset values and timing counts of the serial port
`ifndef FMSP_PARAMS_SVH
`define FMSP_PARAMS_SVH

`define FMSP_A_CTRL     3'h0
`define FMSP_A_DATA     3'h1
`define FMSP_A_STAT     3'h2
`define FMSP_A_MASK     3'h3
`define FMSP_A_CFG      3'h4
`define FMSP_A_ADDR     3'h5
`define FMSP_A_AMSK     3'h6

`define FMSP_B_RXD      0
`define FMSP_B_TXD      1
`define FMSP_B_RX9      2
`define FMSP_B_TX9      3
`define FMSP_B_REN      4
`define FMSP_B_MPC      5
`define FMSP_B_MODE     7:6
`define FMSP_B_OVR      2
`define FMSP_B_FERR     3
`define FMSP_B_TXSEL    1:0
`define FMSP_B_RXSEL    3:2
`define FMSP_B_DBL      4

`define FMSP_MODE_SYNC  2'h0
`define FMSP_MODE_VAR8  2'h1
`define FMSP_MODE_FIX9  2'h2
`define FMSP_MODE_VAR9  2'h3
`define FMSP_SEL_T1     2'h0

`define FMSP_RST_BYTE   8'h00
`define FMSP_RST_MASK   4'h0
`define FMSP_BCAST      8'hff

`define FMSP_SYNC_DIV   4'hc
`define FMSP_SYNC_HALF  4'h6
`define FMSP_SYNC_BITS  4'h8
`define FMSP_FRAME8     4'ha
`define FMSP_FRAME9     4'hb
`define FMSP_OS_LAST    4'hf
`define FMSP_OS_MID     4'h7
`define FMSP_FIX_SLOW   3'h4
`define FMSP_FIX_FAST   3'h2

`endif

// ### fmsp_pkg.sv
// state types of the serial port
package fmsp_pkg;
	typedef enum logic [1:0] {tx_idle, tx_async, tx_sync} fmsp_tx_st_e;
	typedef enum logic {rx_idle, rx_busy} fmsp_rx_st_e;
endpackage

// ### fmsp_rate_tick.sv
// sixteen-times oversampling tick for the asynchronous modes
`timescale 1ns/1ns
`include "fmsp_params.svh"
module fmsp_rate_tick (
	input  wire logic       core_clk,
	input  wire logic       resetn,
	input  wire logic [1:0] mode,
	input  wire logic [1:0] sel,
	input  wire logic       baud_double,
	input  wire logic [3:0] timer_ovf,
	output logic            os_tick
);
	logic [2:0] div_cnt;
	logic       half;
	logic [2:0] lim;
	logic       ovf;

	// fixed mode: core/64 or core/32 baud is core/4 or core/2 at 16x
	assign lim = baud_double ? `FMSP_FIX_FAST : `FMSP_FIX_SLOW;
	assign ovf = timer_ovf[sel];

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			div_cnt <= 3'h0;
		end else if (mode != `FMSP_MODE_FIX9 || div_cnt == lim - 3'h1) begin
			div_cnt <= 3'h0;
		end else begin
			div_cnt <= div_cnt + 3'h1;
		end
	end

	// timer 1 is halved unless doubled, giving overflow/32 or /16
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			half <= 1'b0;
		end else if (timer_ovf[`FMSP_SEL_T1]) begin
			half <= ~half;
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			os_tick <= 1'b0;
		end else if (mode == `FMSP_MODE_FIX9) begin
			os_tick <= (div_cnt == lim - 3'h1);
		end else if (sel == `FMSP_SEL_T1 && !baud_double) begin
			os_tick <= ovf && half;
		end else begin
			os_tick <= ovf;
		end
	end
endmodule // fmsp_rate_tick

// ### fmsp_serial_peer.sv
// serial peer: async frame source and sink, sync-mode data source
`timescale 1ns/1ns
module fmsp_serial_peer #(
	parameter int BIT_CYC = 32
) (
	input  wire logic core_clk,
	input  wire logic serial_tx_pin,
	output logic      line
);
	initial line = 1'b1;

	// a low stop bit is how the bench provokes a framing fault
	task automatic send(input logic [8:0] d, input int nd, input logic stop);
		@(posedge core_clk);
		line <= 1'b0;
		repeat (BIT_CYC) @(posedge core_clk);
		for (int i = 0; i < nd; i++) begin
			line <= d[i];
			repeat (BIT_CYC) @(posedge core_clk);
		end
		line <= stop;
		repeat (BIT_CYC) @(posedge core_clk);
		line <= 1'b1;
	endtask

	// samples mid-bit, payload lsb first, stop bit last
	task automatic recv(input int n, output logic [9:0] v);
		v = 10'h000;
		@(negedge serial_tx_pin);
		repeat (BIT_CYC / 2) @(posedge core_clk);
		for (int i = 0; i < n - 1; i++) begin
			repeat (BIT_CYC) @(posedge core_clk);
			v[i] = serial_tx_pin;
		end
	endtask

	// new bit on each falling shift clock, then release to the pull-up
	task automatic sync_drive(input logic [7:0] d);
		for (int i = 0; i < 8; i++) begin
			@(negedge serial_tx_pin);
			line <= d[i];
		end
		@(posedge serial_tx_pin);
		repeat (6) @(posedge core_clk);
		line <= 1'b1;
	endtask
endmodule // fmsp_serial_peer

// ### fmsp_serial_port.sv
// four-mode serial port: register slave, transmitter, receiver, interrupt
//
// Design decisions made here: the address map and the strobed register port.
`timescale 1ns/1ns
`include "fmsp_params.svh"
module fmsp_serial_port (
	input  wire logic       core_clk,
	input  wire logic       resetn,
	input  wire logic [2:0] addr,
	input  wire logic [7:0] wr_data,
	input  wire logic       wr_en,
	input  wire logic       rd_en,
	output logic      [7:0] rd_data,
	input  wire logic [3:0] timer_ovf,
	input  wire logic       serial_rx_pin_i,
	output logic            serial_rx_pin_o,
	output logic            serial_rx_pin_oe,
	output logic            serial_tx_pin,
	output logic            irq
);
	// control fields
	logic [1:0] mode;
	logic       rx_enable;
	logic       multiproc_check_en;
	logic       tx_ninth_bit;
	logic       rx_ninth_bit;
	logic       tx_done_flag;
	logic       rx_done_flag;
	logic       overrun;
	logic       frame_err;
	logic [3:0] irq_mask;
	logic [1:0] tx_sel;
	logic [1:0] rx_sel;
	logic       baud_double;
	logic [7:0] own_addr;
	logic [7:0] addr_mask;
	logic [7:0] serial_data_buffer;
	logic       unread;

	// decoded bus strobes
	logic wr_ctrl;
	logic wr_data_reg;
	logic wr_stat;
	logic rd_data_reg;
	logic clr_rxd;
	logic clr_txd;

	// transmit side
	fmsp_pkg::fmsp_tx_st_e tx_st;
	logic [10:0] frame;
	logic [3:0]  tx_left;
	logic [3:0]  tx_os;
	logic [3:0]  sync_ph;
	logic        sync_rx;
	logic [7:0]  sync_in;
	logic        tx_os_tick;
	logic        set_txd;
	logic        sync_fin;
	logic        sync_start_tx;
	logic        sync_start_rx;

	// receive side
	fmsp_pkg::fmsp_rx_st_e rx_st;
	logic [9:0] rx_sh;
	logic [3:0] rx_cnt;
	logic [3:0] rx_os;
	logic       rx_q;
	logic       rx_os_tick;
	logic       rx_fin;
	logic [7:0] rx_byte;
	logic       rx_b9;
	logic       rx_stop;
	logic       rx_accept;
	logic       load;
	logic [7:0] load_byte;
	logic       sync_rx_fin;

	function automatic logic nine_bit(input logic [1:0] m);
		nine_bit = m[1];
	endfunction

	function automatic logic [3:0] frame_len(input logic [1:0] m);
		frame_len = nine_bit(m) ? `FMSP_FRAME9 : `FMSP_FRAME8;
	endfunction

	// masked match against own address, or the all-ones broadcast
	function automatic logic addr_hit(input logic [7:0] b, input logic [7:0] own,
		input logic [7:0] msk);
		addr_hit = ((b & msk) == (own & msk)) || (b == `FMSP_BCAST);
	endfunction

	assign wr_ctrl     = wr_en && addr == `FMSP_A_CTRL;
	assign wr_data_reg = wr_en && addr == `FMSP_A_DATA;
	assign wr_stat     = wr_en && addr == `FMSP_A_STAT;
	assign rd_data_reg = rd_en && addr == `FMSP_A_DATA;
	// done flags clear by writing one, through control or status
	assign clr_rxd = (wr_ctrl || wr_stat) && wr_data[`FMSP_B_RXD];
	assign clr_txd = (wr_ctrl || wr_stat) && wr_data[`FMSP_B_TXD];

	fmsp_rate_tick u_tx_rate (
		.core_clk    (core_clk),
		.resetn      (resetn),
		.mode        (mode),
		.sel         (tx_sel),
		.baud_double (baud_double),
		.timer_ovf   (timer_ovf),
		.os_tick     (tx_os_tick)
	);

	fmsp_rate_tick u_rx_rate (
		.core_clk    (core_clk),
		.resetn      (resetn),
		.mode        (mode),
		.sel         (rx_sel),
		.baud_double (baud_double),
		.timer_ovf   (timer_ovf),
		.os_tick     (rx_os_tick)
	);

	// configuration registers
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			mode               <= `FMSP_MODE_SYNC;
			rx_enable          <= 1'b0;
			multiproc_check_en <= 1'b0;
			tx_ninth_bit       <= 1'b0;
		end else if (wr_ctrl) begin
			mode               <= wr_data[`FMSP_B_MODE];
			rx_enable          <= wr_data[`FMSP_B_REN];
			multiproc_check_en <= wr_data[`FMSP_B_MPC];
			tx_ninth_bit       <= wr_data[`FMSP_B_TX9];
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			irq_mask    <= `FMSP_RST_MASK;
			tx_sel      <= `FMSP_SEL_T1;
			rx_sel      <= `FMSP_SEL_T1;
			baud_double <= 1'b0;
			own_addr    <= `FMSP_RST_BYTE;
			addr_mask   <= `FMSP_RST_BYTE;
		end else if (wr_en && addr == `FMSP_A_MASK) begin
			irq_mask <= wr_data[3:0];
		end else if (wr_en && addr == `FMSP_A_CFG) begin
			tx_sel      <= wr_data[`FMSP_B_TXSEL];
			rx_sel      <= wr_data[`FMSP_B_RXSEL];
			baud_double <= wr_data[`FMSP_B_DBL];
		end else if (wr_en && addr == `FMSP_A_ADDR) begin
			own_addr <= wr_data;
		end else if (wr_en && addr == `FMSP_A_AMSK) begin
			addr_mask <= wr_data;
		end
	end

	// synchronous-mode start: a data write sends, otherwise receive when armed
	assign sync_start_tx = tx_st == fmsp_pkg::tx_idle && mode == `FMSP_MODE_SYNC && wr_data_reg;
	// rx_done_flag rises a cycle after the shifter goes idle; hold off a restart then
	assign sync_start_rx = tx_st == fmsp_pkg::tx_idle && mode == `FMSP_MODE_SYNC && !wr_data_reg
		&& rx_enable && !rx_done_flag && !sync_rx_fin;
	assign sync_fin = tx_st == fmsp_pkg::tx_sync && sync_ph == `FMSP_SYNC_DIV - 4'h1
		&& tx_left == 4'h1;

	// transmitter; writes while busy are dropped, there is no transmit queue
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			tx_st   <= fmsp_pkg::tx_idle;
			frame   <= 11'h7ff;
			tx_left <= 4'h0;
			tx_os   <= 4'h0;
			sync_ph <= 4'h0;
			sync_rx <= 1'b0;
			sync_in <= `FMSP_RST_BYTE;
		end else begin
			case (tx_st)
				fmsp_pkg::tx_idle: begin
					tx_os   <= 4'h0;
					sync_ph <= 4'h0;
					if (mode != `FMSP_MODE_SYNC && wr_data_reg) begin
						// stop, ninth (or a second stop), data, start
						frame   <= {1'b1, nine_bit(mode) ? tx_ninth_bit : 1'b1,
							wr_data, 1'b0};
						tx_left <= frame_len(mode);
						tx_st   <= fmsp_pkg::tx_async;
					end else if (sync_start_tx || sync_start_rx) begin
						frame   <= {3'h7, wr_data};
						tx_left <= `FMSP_SYNC_BITS;
						sync_rx <= sync_start_rx;
						tx_st   <= fmsp_pkg::tx_sync;
					end
				end
				fmsp_pkg::tx_async: begin
					if (tx_os_tick) begin
						tx_os <= tx_os + 4'h1;
						if (tx_os == `FMSP_OS_LAST) begin
							frame   <= {1'b1, frame[10:1]};
							tx_left <= tx_left - 4'h1;
							if (tx_left == 4'h1) begin
								tx_st <= fmsp_pkg::tx_idle;
							end
						end
					end
				end
				fmsp_pkg::tx_sync: begin
					// twelve core clocks per bit
					sync_ph <= (sync_ph == `FMSP_SYNC_DIV - 4'h1) ? 4'h0 : sync_ph + 4'h1;
					if (sync_ph == `FMSP_SYNC_HALF - 4'h1) begin
						sync_in <= {serial_rx_pin_i, sync_in[7:1]};
					end
					if (sync_ph == `FMSP_SYNC_DIV - 4'h1) begin
						frame   <= {1'b1, frame[10:1]};
						tx_left <= tx_left - 4'h1;
						if (tx_left == 4'h1) begin
							tx_st   <= fmsp_pkg::tx_idle;
							sync_rx <= 1'b0;
						end
					end
				end
				default: tx_st <= fmsp_pkg::tx_idle;
			endcase
		end
	end

	// transmit done at start of the stop bit, or end of the eighth shift
	assign set_txd = (tx_st == fmsp_pkg::tx_async && tx_os_tick && tx_os == `FMSP_OS_LAST
		&& tx_left == 4'h2) || (sync_fin && !sync_rx);

	// pins: async data on tx; sync clock on tx, data on open-drain rx pin
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			serial_tx_pin    <= 1'b1;
			serial_rx_pin_oe <= 1'b0;
		end else if (tx_st == fmsp_pkg::tx_async) begin
			serial_tx_pin    <= frame[0];
			serial_rx_pin_oe <= 1'b0;
		end else if (tx_st == fmsp_pkg::tx_sync) begin
			serial_tx_pin    <= sync_ph >= `FMSP_SYNC_HALF;
			serial_rx_pin_oe <= !sync_rx && !frame[0];
		end else begin
			serial_tx_pin    <= 1'b1;
			serial_rx_pin_oe <= 1'b0;
		end
	end
	assign serial_rx_pin_o = 1'b0;

	// async receiver, runs alongside the transmitter
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			rx_q <= 1'b1;
		end else begin
			rx_q <= serial_rx_pin_i;
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			rx_st  <= fmsp_pkg::rx_idle;
			rx_sh  <= 10'h000;
			rx_cnt <= 4'h0;
			rx_os  <= 4'h0;
			rx_fin <= 1'b0;
		end else begin
			rx_fin <= 1'b0;
			case (rx_st)
				fmsp_pkg::rx_idle: begin
					rx_os  <= 4'h0;
					rx_cnt <= 4'h0;
					if (mode != `FMSP_MODE_SYNC && rx_enable && rx_q && !serial_rx_pin_i) begin
						rx_st <= fmsp_pkg::rx_busy;
					end
				end
				fmsp_pkg::rx_busy: begin
					if (!rx_enable || mode == `FMSP_MODE_SYNC) begin
						rx_st <= fmsp_pkg::rx_idle;
					end else if (rx_os_tick) begin
						rx_os <= rx_os + 4'h1;
						// sample mid-bit; a start bit high again is a glitch
						if (rx_os == `FMSP_OS_MID) begin
							rx_cnt <= rx_cnt + 4'h1;
							if (rx_cnt == 4'h0 && serial_rx_pin_i) begin
								rx_st <= fmsp_pkg::rx_idle;
							end else if (rx_cnt != 4'h0) begin
								rx_sh <= {serial_rx_pin_i, rx_sh[9:1]};
							end
							if (rx_cnt == frame_len(mode) - 4'h1) begin
								rx_fin <= 1'b1;
								rx_st  <= fmsp_pkg::rx_idle;
							end
						end
					end
				end
				default: rx_st <= fmsp_pkg::rx_idle;
			endcase
		end
	end

	assign rx_byte = nine_bit(mode) ? rx_sh[7:0] : rx_sh[8:1];
	assign rx_b9   = nine_bit(mode) ? rx_sh[8] : rx_sh[9];
	assign rx_stop = rx_sh[9];
	// nine-bit modes check ninth bit and address; eight-bit checks stop
	assign rx_accept = !rx_done_flag && (!multiproc_check_en ||
		(nine_bit(mode) ? (rx_b9 && addr_hit(rx_byte, own_addr, addr_mask)) : rx_stop));
	// sync receive lands in the holding register one cycle after the eighth bit
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			sync_rx_fin <= 1'b0;
		end else begin
			sync_rx_fin <= sync_fin && sync_rx;
		end
	end
	assign load      = (rx_fin && rx_accept) || sync_rx_fin;
	assign load_byte = sync_rx_fin ? sync_in : rx_byte;

	// holding register, separate from the shifters
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			serial_data_buffer <= `FMSP_RST_BYTE;
			rx_ninth_bit       <= 1'b0;
		end else if (load) begin
			serial_data_buffer <= load_byte;
			if (!sync_rx_fin) begin
				rx_ninth_bit <= rx_b9;
			end
		end
	end

	// sticky flags: a set in the same cycle as a clear wins
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			rx_done_flag <= 1'b0;
			tx_done_flag <= 1'b0;
		end else begin
			rx_done_flag <= load || (rx_done_flag && !clr_rxd);
			tx_done_flag <= set_txd || (tx_done_flag && !clr_txd);
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			unread    <= 1'b0;
			overrun   <= 1'b0;
			frame_err <= 1'b0;
		end else begin
			unread    <= load || (unread && !rd_data_reg);
			overrun   <= (load && unread && !rd_data_reg) ||
				(overrun && !(wr_stat && wr_data[`FMSP_B_OVR]));
			frame_err <= (rx_fin && !rx_stop) ||
				(frame_err && !(wr_stat && wr_data[`FMSP_B_FERR]));
		end
	end

	// one level interrupt; with the mask at zero the flags are polled
	always_comb begin
		irq = |({frame_err, overrun, tx_done_flag, rx_done_flag} & irq_mask);
	end

	// read data stands the cycle after the read strobe
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			rd_data <= `FMSP_RST_BYTE;
		end else if (!rd_en) begin
			rd_data <= `FMSP_RST_BYTE;
		end else if (addr == `FMSP_A_CTRL) begin
			rd_data <= {mode, multiproc_check_en, rx_enable, tx_ninth_bit,
				rx_ninth_bit, tx_done_flag, rx_done_flag};
		end else if (addr == `FMSP_A_DATA) begin
			rd_data <= serial_data_buffer;
		end else if (addr == `FMSP_A_STAT) begin
			rd_data <= {4'h0, frame_err, overrun, tx_done_flag, rx_done_flag};
		end else if (addr == `FMSP_A_MASK) begin
			rd_data <= {4'h0, irq_mask};
		end else if (addr == `FMSP_A_CFG) begin
			rd_data <= {3'h0, baud_double, rx_sel, tx_sel};
		end else if (addr == `FMSP_A_ADDR) begin
			rd_data <= own_addr;
		end else if (addr == `FMSP_A_AMSK) begin
			rd_data <= addr_mask;
		end else begin
			rd_data <= `FMSP_RST_BYTE;
		end
	end
endmodule // fmsp_serial_port

// ### fmsp_serial_port_properties.sv
// concurrent checks on the serial port's outer pins
`timescale 1ns/1ns
`include "fmsp_params.svh"
module fmsp_serial_port_properties (
	input wire logic       core_clk,
	input wire logic       resetn,
	input wire logic [2:0] addr,
	input wire logic [7:0] wr_data,
	input wire logic       wr_en,
	input wire logic       rd_en,
	input wire logic [7:0] rd_data,
	input wire logic       serial_rx_pin_o,
	input wire logic       serial_rx_pin_oe,
	input wire logic       serial_tx_pin,
	input wire logic       irq
);
	logic [7:3] ctrl_q;
	logic [3:0] mask_q;
	logic       sync_m;

	// shadows rebuilt from bus writes only, never from internal state
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) ctrl_q <= 5'h00;
		else if (wr_en && addr == `FMSP_A_CTRL) ctrl_q <= wr_data[7:3];
	end
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) mask_q <= 4'h0;
		else if (wr_en && addr == `FMSP_A_MASK) mask_q <= wr_data[3:0];
	end
	assign sync_m = ctrl_q[7:6] == `FMSP_MODE_SYNC;

	a_reset_idle_pins: assert property (@(posedge core_clk) $rose(resetn) |-> serial_tx_pin
		&& !serial_rx_pin_oe && !irq && rd_data == 8'h00) else $error("pins not idle after reset");
	a_rd_data_idle: assert property (@(posedge core_clk) disable iff (!resetn)
		!$past(rd_en) |-> rd_data == 8'h00) else $error("read data outside read slot");
	a_unmapped_read: assert property (@(posedge core_clk) disable iff (!resetn)
		rd_en && addr == 3'h7 |=> rd_data == 8'h00) else $error("unmapped read not zero");
	a_ctrl_mode_readback: assert property (@(posedge core_clk) disable iff (!resetn)
		rd_en && addr == `FMSP_A_CTRL |=> rd_data[7:3] == ctrl_q) else $error("control readback");
	a_mask_readback: assert property (@(posedge core_clk) disable iff (!resetn)
		rd_en && addr == `FMSP_A_MASK |=> rd_data[3:0] == mask_q) else $error("mask readback");
	a_masked_irq_low: assert property (@(posedge core_clk) disable iff (!resetn)
		mask_q == 4'h0 |-> !irq) else $error("irq with all sources masked");
	a_open_drain_low: assert property (@(posedge core_clk) disable iff (!resetn)
		serial_rx_pin_o == 1'b0) else $error("receive pin driven high");
	a_oe_sync_only: assert property (@(posedge core_clk) disable iff (!resetn)
		!sync_m |-> !serial_rx_pin_oe) else $error("receive pin driven in async mode");
	a_sync_low_phase: assert property (@(posedge core_clk) disable iff (!resetn)
		sync_m && $fell(serial_tx_pin) |=> !serial_tx_pin [*5] ##1 serial_tx_pin)
		else $error("shift clock low phase not six cycles");
	a_sync_high_phase: assert property (@(posedge core_clk) disable iff (!resetn)
		sync_m && $rose(serial_tx_pin) |=> serial_tx_pin [*5]) else $error("shift clock high short");
	a_async_start_min: assert property (@(posedge core_clk) disable iff (!resetn)
		!sync_m && $fell(serial_tx_pin) |=> !serial_tx_pin [*8]) else $error("start bit too short");
endmodule // fmsp_serial_port_properties

bind fmsp_serial_port fmsp_serial_port_properties u_fmsp_serial_port_properties (
	.core_clk(core_clk), .resetn(resetn), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
	.rd_en(rd_en), .rd_data(rd_data), .serial_rx_pin_o(serial_rx_pin_o),
	.serial_rx_pin_oe(serial_rx_pin_oe), .serial_tx_pin(serial_tx_pin), .irq(irq));

// ### fmsp_serial_port_tb.sv
// self-checking bench for the four-mode serial port
`timescale 1ns/1ns
`include "fmsp_params.svh"
module fmsp_serial_port_tb;
	typedef struct packed {
		logic [7:0] cfg;
		logic [7:0] ctrl;
		logic [7:0] data;
		logic [3:0] len;
		logic [9:0] frame;
	} fmsp_row_s;

	logic       core_clk;
	logic       resetn = 1'b0;
	logic [2:0] addr = 3'h0;
	logic [7:0] wr_data = 8'h00;
	logic       wr_en = 1'b0;
	logic       rd_en = 1'b0;
	logic [7:0] rd_data;
	logic [3:0] timer_ovf = 4'h0;
	logic       rx_line;
	logic       peer_line;
	logic       serial_rx_pin_o;
	logic       serial_rx_pin_oe;
	logic       serial_tx_pin;
	logic       irq;
	logic [7:0] v8;
	logic [9:0] v10;
	int         err_total = 0;
	int         total_checks = 0;
	fmsp_row_s  rows [3];

	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	// every timer overflows each second cycle: sixteen ticks give a 32-cycle bit
	always @(posedge core_clk) timer_ovf <= (resetn && timer_ovf == 4'h0) ? 4'hf : 4'h0;
	// open drain with pull-up: the port can only pull low
	assign rx_line = serial_rx_pin_oe ? serial_rx_pin_o : peer_line;

	fmsp_serial_port u_fmsp_serial_port (.core_clk(core_clk), .resetn(resetn), .addr(addr),
		.wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
		.timer_ovf(timer_ovf), .serial_rx_pin_i(rx_line), .serial_rx_pin_o(serial_rx_pin_o),
		.serial_rx_pin_oe(serial_rx_pin_oe), .serial_tx_pin(serial_tx_pin), .irq(irq));
	fmsp_serial_peer u_fmsp_serial_peer (.core_clk(core_clk), .serial_tx_pin(serial_tx_pin),
		.line(peer_line));

	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge core_clk);
		addr <= a;
		wr_data <= d;
		wr_en <= 1'b1;
		@(posedge core_clk);
		wr_en <= 1'b0;
		#1;
	endtask

	task automatic chk(input logic [9:0] got, input logic [9:0] exp);
		total_checks++;
		if (got !== exp) begin
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
			err_total++;
		end
	endtask

	task automatic rchk(input logic [2:0] a, input logic [7:0] exp);
		@(posedge core_clk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge core_clk);
		rd_en <= 1'b0;
		#1;
		chk({2'b00, rd_data}, {2'b00, exp});
	endtask

	task automatic complete_run;
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	initial begin
		repeat (30000) @(posedge core_clk);
		err_total++;
		complete_run;
	end

	initial begin
		rows[0] = '{8'h10, 8'h98, 8'ha5, 4'hb, 10'h3a5};
		rows[1] = '{8'h10, 8'h40, 8'hc3, 4'ha, 10'h1c3};
		rows[2] = '{8'h05, 8'hc8, 8'h3c, 4'hb, 10'h33c};
		repeat (16) @(posedge core_clk);
		resetn <= 1'b1;
		@(posedge core_clk);
		#1;
		chk(serial_tx_pin, 10'h001);
		chk(irq, 10'h000);
		rchk(`FMSP_A_CTRL, 8'h00);
		rchk(3'h7, 8'h00);
		$display("test reset done");
		wr(`FMSP_A_MASK, 8'h03);
		foreach (rows[i]) begin
			wr(`FMSP_A_CFG, rows[i].cfg);
			wr(`FMSP_A_CTRL, rows[i].ctrl);
			fork
				begin
					wr(`FMSP_A_DATA, rows[i].data);
					repeat (40) @(posedge core_clk);
					wr(`FMSP_A_DATA, ~rows[i].data);
				end
				u_fmsp_serial_peer.recv(rows[i].len, v10);
			join
			chk(v10, rows[i].frame);
			repeat (32) @(posedge core_clk);
			rchk(`FMSP_A_CTRL, rows[i].ctrl | 8'h02);
			chk(irq, 10'h001);
			wr(`FMSP_A_CTRL, rows[i].ctrl | 8'h02);
			chk(irq, 10'h000);
		end
		$display("test async transmit done");
		wr(`FMSP_A_CFG, 8'h10);
		wr(`FMSP_A_STAT, 8'h0f);
		wr(`FMSP_A_CTRL, 8'h90);
		u_fmsp_serial_peer.send(9'h15a, 9, 1'b1);
		repeat (8) @(posedge core_clk);
		rchk(`FMSP_A_CTRL, 8'h95);
		wr(`FMSP_A_CTRL, 8'h91);
		u_fmsp_serial_peer.send(9'h0c3, 9, 1'b1);
		repeat (8) @(posedge core_clk);
		rchk(`FMSP_A_STAT, 8'h05);
		rchk(`FMSP_A_DATA, 8'hc3);
		u_fmsp_serial_peer.send(9'h1ff, 9, 1'b0);
		repeat (8) @(posedge core_clk);
		rchk(`FMSP_A_STAT, 8'h0d);
		wr(`FMSP_A_STAT, 8'h0f);
		rchk(`FMSP_A_STAT, 8'h00);
		wr(`FMSP_A_ADDR, 8'h21);
		wr(`FMSP_A_AMSK, 8'hff);
		wr(`FMSP_A_CTRL, 8'hb0);
		u_fmsp_serial_peer.send(9'h021, 9, 1'b1);
		repeat (8) @(posedge core_clk);
		rchk(`FMSP_A_CTRL, 8'hb0);
		u_fmsp_serial_peer.send(9'h121, 9, 1'b1);
		repeat (8) @(posedge core_clk);
		rchk(`FMSP_A_CTRL, 8'hb5);
		rchk(`FMSP_A_DATA, 8'h21);
		$display("test async receive done");
		wr(`FMSP_A_CTRL, 8'h01);
		wr(`FMSP_A_STAT, 8'h0f);
		fork
			wr(`FMSP_A_DATA, 8'h96);
			for (int b = 0; b < 8; b++) begin
				@(posedge serial_tx_pin);
				#1;
				v8[b] = rx_line;
			end
		join
		chk({2'b00, v8}, 10'h096);
		repeat (20) @(posedge core_clk);
		// rx_ninth_bit still holds the ninth bit of the last async load
		rchk(`FMSP_A_CTRL, 8'h06);
		fork
			wr(`FMSP_A_CTRL, 8'h12);
			u_fmsp_serial_peer.sync_drive(8'h4b);
		join
		repeat (20) @(posedge core_clk);
		rchk(`FMSP_A_CTRL, 8'h15);
		rchk(`FMSP_A_DATA, 8'h4b);
		// reception must stay stopped while rx_done_flag is set
		repeat (120) @(posedge core_clk);
		rchk(`FMSP_A_DATA, 8'h4b);
		$display("test sync done");
		@(posedge core_clk);
		resetn <= 1'b0;
		repeat (3) @(posedge core_clk);
		resetn <= 1'b1;
		@(posedge core_clk);
		#1;
		chk(serial_tx_pin, 10'h001);
		rchk(`FMSP_A_CTRL, 8'h00);
		$display("test second reset done");
		complete_run;
	end
endmodule // fmsp_serial_port_tb
